// ### inc/bdce_dly_if.sv
// carrier between the register bank and its recovery delay timer
`timescale 1ns/1ns
`default_nettype none
interface bdce_dly_if;
  logic load; // one-cycle start of a delay
  logic [7:0] value; // steps of the selected delay field
  logic busy; // timer counting
  logic done; // one-cycle pulse, delay over
  modport ctl (output load, output value, input busy, input done);
  modport tmr (input load, input value, output busy, output done);
endinterface
`default_nettype wire

// ### inc/bdce_pkg.sv
// shared constants for the balance delay and channel enable register bank
package bdce_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_BAL_RECOVERY_DELAY = 8'h63;
  localparam logic [7:0] IDX_CELL_CHANNEL_ENABLE = 8'h64;
  localparam logic [11:0] ADDR_BAL_RECOVERY_DELAY = {2'h0, IDX_BAL_RECOVERY_DELAY, 2'h0};
  localparam logic [11:0] ADDR_CELL_CHANNEL_ENABLE = {2'h0, IDX_CELL_CHANNEL_ENABLE, 2'h0};
  // reset values
  localparam logic [15:0] RST_BAL_RECOVERY_DELAY = 16'h0000;
  localparam logic [15:0] RST_CELL_CHANNEL_ENABLE = 16'h0000;
  // field positions
  localparam int CELL_DLY_LSB = 8;
  localparam int SW_DLY_LSB = 0;
  localparam int DLY_W = 8;
  localparam int STACK_EN_BIT = 14;
  localparam int CELL_COUNT = 14;
  localparam logic [15:0] CHAN_EN_MASK = 16'h7fff;
  // measure-during-balancing code bit: 1x selects post-pair measurement
  localparam int MEAS_BAL_HI_BIT = 1;
  // delay step timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int STEP_US = 96;
  localparam int STEP_CYCLES = (STEP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // delay controller states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_FIRE = 2'b11
  } bdce_state_t;
endpackage

// ### rtl/bdce_delay_timer.sv
// recovery delay down-counter paced by a step tick
`timescale 1ns/1ns
`default_nettype none
module bdce_delay_timer #(
  parameter int TICK_CYCLES = bdce_pkg::STEP_CYCLES // clocks per delay step
) (
  input wire logic clk, // device clock
  input wire logic rst, // synchronous reset, high
  bdce_dly_if.tmr dly // load in, busy and done out
);
  logic [15:0] tick_cnt_reg; // step divider
  logic tick; // one-cycle step enable
  logic [7:0] steps_reg; // remaining steps
  logic busy_reg; // counting
  logic done_reg; // end pulse

  assign tick = (tick_cnt_reg == 16'(TICK_CYCLES - 1));
  assign dly.busy = busy_reg;
  assign dly.done = done_reg;

  // divider restarts on load so the first step is a full step
  always_ff @(posedge clk) begin
    if (rst || dly.load || !busy_reg || tick) begin
      tick_cnt_reg <= 16'h0000; // RQ11
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end
  end

  // down-counter, zero ends the wait
  always_ff @(posedge clk) begin
    if (rst) begin
      steps_reg <= 8'h00;
      busy_reg <= 1'b0;
    end else if (dly.load) begin
      steps_reg <= dly.value; // RQ11
      busy_reg <= 1'b1;
    end else if (busy_reg && steps_reg == 8'h00) begin
      busy_reg <= 1'b0; // RQ11
    end else if (busy_reg && tick) begin
      steps_reg <= steps_reg - 8'h01; // RQ11
    end
  end

  // done pulse one cycle after zero is seen
  always_ff @(posedge clk) begin
    if (rst) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= busy_reg && !dly.load && steps_reg == 8'h00; // RQ11
    end
  end
endmodule
`default_nettype wire

// ### rtl/bdce_top.sv
// balance recovery delay and cell channel enable registers with apb slave
// What this block does
// RQ1: cell-path delay is upper byte, 96us steps
// RQ2: cell delay used when alternate mux clear
// RQ3: switch-path delay is lower byte, 96us steps
// RQ4: switch delay used when alternate mux set
// RQ5: both delay fields reset zero, plain read/write
// RQ6: stack enable adds block channel and divider
// RQ7: comparator scans never measure block channel
// RQ8: divider held engaged for whole scan
// RQ9: software sets stack enable only with alternate mux; the block takes stack enable whatever ALTERNATE_MUX_SELECT is
// RQ10: fourteen cell enables, bit k is cell k+1
// RQ11: delay is down-counter on 96us tick
`timescale 1ns/1ns
`default_nettype none
module bdce_top #(
  parameter int TICK_CYCLES = bdce_pkg::STEP_CYCLES // clocks per 96us step
) (
  input wire logic CLK, // 100 MHz device clock
  input wire logic RST, // synchronous reset, high
  // apb slave
  input wire logic PSEL, // slave select
  input wire logic PENABLE, // access phase
  input wire logic PWRITE, // write when high
  input wire logic [11:0] PADDR, // byte address
  input wire logic [31:0] PWDATA, // write data
  input wire logic [3:0] PSTRB, // byte lane strobes
  output logic [31:0] PRDATA, // read data
  output logic PREADY, // transfer complete
  output logic PSLVERR, // unmapped address
  // sequencer context
  input wire logic SCAN_ACTIVE, // level, scan in progress
  input wire logic SCAN_IS_ADC, // level, scan uses adc, low for comparator
  input wire logic MANUAL_BAL, // level, manual balancing mode
  input wire logic AUTO_BAL, // level, automatic balancing or discharge
  input wire logic AUTO_SWITCH_DISABLE, // level, auto switch disable
  input wire logic ALTERNATE_MUX_SELECT, // level, switch-sense mux chosen
  input wire logic [1:0] MEASURE_DURING_BALANCING, // level, measurement mode
  input wire logic MEAS_REQ, // pulse, manual adc measurement request
  input wire logic PAIR_DONE, // pulse, even/odd discharge pair finished
  // to sequencer and analog front
  output logic MEAS_START, // pulse, start adc measurement
  output logic DELAY_BUSY, // level, recovery wait running
  output logic STACK_MEASURE, // level, block channel in this scan
  output logic DIVIDER_ENGAGE, // level, block divider connected
  output logic [13:0] CELL_MEASURE_EN // level, per-cell enables
);
  // register storage
  logic [15:0] bal_recovery_delay_reg; // both delay fields
  logic [15:0] cell_channel_enable_reg; // stack enable and cell enables
  logic [15:0] bal_recovery_delay_next; // value after write
  logic [15:0] cell_channel_enable_next; // value after write
  // bus
  logic pready_reg; // one cycle per access
  logic [31:0] prdata_reg; // captured read word
  logic pslverr_reg; // error flag
  logic wr_en; // write takes effect this edge
  logic addr_hit_dly; // decode of delay register
  logic addr_hit_chan; // decode of channel register
  // sequencing
  bdce_pkg::bdce_state_t state_reg; // delay controller state
  bdce_pkg::bdce_state_t state_next; // next state
  logic manual_case; // manual request needing a delay
  logic auto_case; // automatic pair needing a delay
  logic plain_case; // manual request with no delay
  logic [7:0] sel_delay; // delay field chosen by mux select
  logic meas_start_reg; // start pulse
  logic scan_active_d_reg; // previous scan level
  logic stack_scan_reg; // block channel taken for this scan
  logic [13:0] cell_en_reg; // cell enable output copy
  logic delay_busy_reg; // busy output copy

  bdce_dly_if dly (); // link to the timer

  // merge a 16-bit register with the enabled low byte lanes
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] strb,
                                             input logic [15:0] mask);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      res[15:8] = wd[15:8];
    end
    lane_merge = res & mask;
  endfunction

  // address decode
  assign addr_hit_dly = (PADDR == bdce_pkg::ADDR_BAL_RECOVERY_DELAY);
  assign addr_hit_chan = (PADDR == bdce_pkg::ADDR_CELL_CHANNEL_ENABLE);

  // writes land at the completing access edge only
  assign wr_en = PSEL && PENABLE && pready_reg && PWRITE;

  // next register values, reserved bit 15 of channel register stays zero
  always_comb begin
    bal_recovery_delay_next = bal_recovery_delay_reg;
    cell_channel_enable_next = cell_channel_enable_reg;
    if (wr_en && addr_hit_dly) begin
      bal_recovery_delay_next = lane_merge(bal_recovery_delay_reg, PWDATA, PSTRB,
                                           16'hffff); // RQ5
    end
    if (wr_en && addr_hit_chan) begin
      cell_channel_enable_next = lane_merge(cell_channel_enable_reg, PWDATA, PSTRB,
                                            bdce_pkg::CHAN_EN_MASK); // RQ10
    end
  end

  // delay register, reset gives no added recovery wait
  always_ff @(posedge CLK) begin
    if (RST) begin
      bal_recovery_delay_reg <= bdce_pkg::RST_BAL_RECOVERY_DELAY; // RQ5
    end else begin
      bal_recovery_delay_reg <= bal_recovery_delay_next;
    end
  end

  // channel enable register
  always_ff @(posedge CLK) begin
    if (RST) begin
      cell_channel_enable_reg <= bdce_pkg::RST_CELL_CHANNEL_ENABLE; // RQ10
    end else begin
      cell_channel_enable_reg <= cell_channel_enable_next;
    end
  end

  // ready rises in the access phase, so every access has no wait state
  always_ff @(posedge CLK) begin
    if (RST) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= PSEL && !PENABLE;
    end
  end

  // read data and error captured in the setup cycle
  always_ff @(posedge CLK) begin
    if (RST) begin
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else if (PSEL && !PENABLE) begin
      pslverr_reg <= !(addr_hit_dly || addr_hit_chan);
      if (PWRITE) begin
        prdata_reg <= 32'h00000000; // reads only return data
      end else if (addr_hit_dly) begin
        prdata_reg <= {16'h0000, bal_recovery_delay_reg}; // RQ5
      end else if (addr_hit_chan) begin
        prdata_reg <= {16'h0000, cell_channel_enable_reg};
      end else begin
        prdata_reg <= 32'h00000000; // unmapped reads as zero
      end
    end else if (!PSEL) begin
      pslverr_reg <= 1'b0; // error only shown with its transfer
    end
  end

  assign PREADY = pready_reg;
  assign PRDATA = prdata_reg;
  assign PSLVERR = pslverr_reg;

  // the two situations that insert a recovery wait
  assign manual_case = MEAS_REQ && MANUAL_BAL && AUTO_SWITCH_DISABLE; // RQ2 RQ4
  assign auto_case = PAIR_DONE && AUTO_BAL &&
                     MEASURE_DURING_BALANCING[bdce_pkg::MEAS_BAL_HI_BIT]; // RQ2 RQ4
  // a manual request without the switch disable starts at once
  assign plain_case = MEAS_REQ && !manual_case;

  // mux select picks which field is waited out
  always_comb begin
    if (ALTERNATE_MUX_SELECT) begin
      sel_delay = bal_recovery_delay_reg[bdce_pkg::SW_DLY_LSB +: bdce_pkg::DLY_W]; // RQ3 RQ4
    end else begin
      sel_delay = bal_recovery_delay_reg[bdce_pkg::CELL_DLY_LSB +: bdce_pkg::DLY_W]; // RQ1 RQ2
    end
  end

  // timer load happens when idle and a delayed case arrives
  assign dly.load = (state_reg == bdce_pkg::ST_IDLE) && (manual_case || auto_case);
  assign dly.value = sel_delay;

  // delay controller next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      bdce_pkg::ST_IDLE: begin
        if (manual_case || auto_case) begin
          state_next = bdce_pkg::ST_WAIT; // RQ11
        end else if (plain_case) begin
          state_next = bdce_pkg::ST_FIRE; // no wait asked for
        end
      end
      bdce_pkg::ST_WAIT: begin
        if (dly.done) begin
          state_next = bdce_pkg::ST_FIRE; // RQ11
        end
      end
      bdce_pkg::ST_FIRE: begin
        state_next = bdce_pkg::ST_IDLE;
      end
      default: begin
        state_next = bdce_pkg::ST_IDLE; // code 2'b10 is illegal
      end
    endcase
  end

  // controller state; requests during a wait are dropped, one wait at a time
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_reg <= bdce_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // start pulse registered from the fire state
  always_ff @(posedge CLK) begin
    if (RST) begin
      meas_start_reg <= 1'b0;
    end else begin
      meas_start_reg <= (state_next == bdce_pkg::ST_FIRE); // RQ11
    end
  end

  // busy flag copy of the wait state
  always_ff @(posedge CLK) begin
    if (RST) begin
      delay_busy_reg <= 1'b0;
    end else begin
      delay_busy_reg <= (state_next == bdce_pkg::ST_WAIT);
    end
  end

  // block channel latched at scan start so a mid-scan write cannot drop the divider
  always_ff @(posedge CLK) begin
    if (RST) begin
      scan_active_d_reg <= 1'b0;
      stack_scan_reg <= 1'b0;
    end else begin
      scan_active_d_reg <= SCAN_ACTIVE;
      if (!SCAN_ACTIVE) begin
        stack_scan_reg <= 1'b0; // RQ8
      end else if (!scan_active_d_reg) begin
        stack_scan_reg <= cell_channel_enable_reg[bdce_pkg::STACK_EN_BIT] &&
                          SCAN_IS_ADC; // RQ6 RQ7
      end
    end
  end

  // cell enables passed to the sequencer
  always_ff @(posedge CLK) begin
    if (RST) begin
      cell_en_reg <= 14'h0000;
    end else begin
      cell_en_reg <= cell_channel_enable_reg[bdce_pkg::CELL_COUNT-1:0]; // RQ10
    end
  end

  assign MEAS_START = meas_start_reg;
  assign DELAY_BUSY = delay_busy_reg;
  assign STACK_MEASURE = stack_scan_reg; // RQ6
  assign DIVIDER_ENGAGE = stack_scan_reg; // RQ8
  assign CELL_MEASURE_EN = cell_en_reg;

  // step timer
  bdce_delay_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .clk(CLK),
    .rst(RST),
    .dly(dly)
  );
endmodule
`default_nettype wire

// ### rtl/unused_placeholder_none.sv
// intentionally empty design unit list; holds no logic
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ### test/bdce_asserts.sv
// concurrent checks on the balance delay and channel enable bank ports
`timescale 1ns/1ns
`default_nettype none
module bdce_asserts #(
  parameter int TICK_CYCLES = bdce_pkg::STEP_CYCLES // clocks per delay step
) (
  input wire logic CLK, // device clock
  input wire logic RST, // sync reset, high
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access phase
  input wire logic PWRITE, // apb write
  input wire logic [11:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  input wire logic [3:0] PSTRB, // apb lanes
  input wire logic PREADY, // apb ready
  input wire logic PSLVERR, // apb error
  input wire logic SCAN_ACTIVE, // scan running
  input wire logic SCAN_IS_ADC, // adc scan
  input wire logic MANUAL_BAL, // manual balancing
  input wire logic AUTO_SWITCH_DISABLE, // auto switch disable
  input wire logic MEAS_REQ, // manual request
  input wire logic MEAS_START, // measurement start
  input wire logic DELAY_BUSY, // wait running
  input wire logic STACK_MEASURE, // block channel on
  input wire logic DIVIDER_ENGAGE, // divider on
  input wire logic [13:0] CELL_MEASURE_EN // cell enables
);
  localparam logic [11:0] DLY_A = bdce_pkg::ADDR_BAL_RECOVERY_DELAY; // delay register
  localparam logic [11:0] CH_A = bdce_pkg::ADDR_CELL_CHANNEL_ENABLE; // channel register
  logic [13:0] wd_low; // cell field of write data
  int busy_cnt_reg; // length of the running wait
  logic acc; // completing transfer
  assign wd_low = PWDATA[13:0];
  assign acc = PSEL && PENABLE && PREADY;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // longest legal wait is a full field of steps plus pipeline slack
  always_ff @(posedge CLK) begin
    if (RST || !DELAY_BUSY) begin
      busy_cnt_reg <= 0;
    end else begin
      busy_cnt_reg <= busy_cnt_reg + 1;
    end
  end
  apb_ready_a: assert property (PSEL && !PENABLE ##1 PSEL && PENABLE |-> PREADY)
    else $error("ready missing in access cycle");
  unmapped_err_a: assert property (acc && PADDR != DLY_A && PADDR != CH_A |-> PSLVERR)
    else $error("unmapped access without error");
  cell_copy_a: assert property (acc && PWRITE && PADDR == CH_A && PSTRB[1:0] == 2'h3
    |-> ##2 CELL_MEASURE_EN == $past(wd_low, 2)) else $error("cell enables not copied");
  wait_start_a: assert property (MEAS_REQ && MANUAL_BAL && AUTO_SWITCH_DISABLE &&
    !DELAY_BUSY && !MEAS_START |=> DELAY_BUSY) else $error("wait did not begin");
  busy_end_a: assert property ($fell(DELAY_BUSY) |-> MEAS_START)
    else $error("wait ended without start");
  start_pulse_a: assert property (MEAS_START |=> !MEAS_START)
    else $error("start longer than one cycle");
  busy_bound_a: assert property (busy_cnt_reg <= 255 * TICK_CYCLES + 4)
    else $error("recovery wait too long");
  comparator_scan_a: assert property ($rose(SCAN_ACTIVE) && !SCAN_IS_ADC |=> !STACK_MEASURE)
    else $error("block channel in comparator scan");
  divider_hold_a: assert property (SCAN_ACTIVE && STACK_MEASURE |=> STACK_MEASURE)
    else $error("divider dropped mid scan");
  divider_release_a: assert property (!SCAN_ACTIVE |=> !STACK_MEASURE)
    else $error("divider held after scan");
  divider_same_a: assert property (DIVIDER_ENGAGE == STACK_MEASURE)
    else $error("divider differs from block channel");
endmodule
bind bdce_top bdce_asserts #(.TICK_CYCLES(TICK_CYCLES)) chk_i (.CLK(CLK), .RST(RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PSTRB(PSTRB), .PREADY(PREADY), .PSLVERR(PSLVERR), .SCAN_ACTIVE(SCAN_ACTIVE),
  .SCAN_IS_ADC(SCAN_IS_ADC), .MANUAL_BAL(MANUAL_BAL), .MEAS_REQ(MEAS_REQ),
  .AUTO_SWITCH_DISABLE(AUTO_SWITCH_DISABLE), .MEAS_START(MEAS_START),
  .DELAY_BUSY(DELAY_BUSY), .STACK_MEASURE(STACK_MEASURE),
  .DIVIDER_ENGAGE(DIVIDER_ENGAGE), .CELL_MEASURE_EN(CELL_MEASURE_EN));
`default_nettype wire

// ### test/bdce_test.sv
// self-checking bench for the balance delay and channel enable bank
`timescale 1ns/1ns
`default_nettype none
module bdce_test;
  localparam int TICK = 4; // short step keeps waits brief
  localparam int LIMIT = 3000; // cycle ceiling for the run
  localparam logic [11:0] DLY_A = bdce_pkg::ADDR_BAL_RECOVERY_DELAY; // delay register
  localparam logic [11:0] CH_A = bdce_pkg::ADDR_CELL_CHANNEL_ENABLE; // channel register
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [3:0] strb;
    logic [31:0] rdata;
    logic err;
  } bdce_row_t;
  logic CLK = 1'h0, RST = 1'h1, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA;
  logic [3:0] PSTRB = 4'h0;
  logic PREADY, PSLVERR, MEAS_START, DELAY_BUSY, STACK_MEASURE, DIVIDER_ENGAGE;
  logic SCAN_ACTIVE = 1'h0, SCAN_IS_ADC = 1'h0, MANUAL_BAL = 1'h0, AUTO_BAL = 1'h0;
  logic AUTO_SWITCH_DISABLE = 1'h0, ALTERNATE_MUX_SELECT = 1'h0;
  logic MEAS_REQ = 1'h0, PAIR_DONE = 1'h0;
  logic [1:0] MEASURE_DURING_BALANCING = 2'h0;
  logic [13:0] CELL_MEASURE_EN;
  int err_total = 0, n_tests = 0, cyc = 0;
  bdce_top #(.TICK_CYCLES(TICK)) dut (.CLK(CLK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SCAN_ACTIVE(SCAN_ACTIVE),
    .SCAN_IS_ADC(SCAN_IS_ADC), .MANUAL_BAL(MANUAL_BAL), .AUTO_BAL(AUTO_BAL),
    .AUTO_SWITCH_DISABLE(AUTO_SWITCH_DISABLE), .ALTERNATE_MUX_SELECT(ALTERNATE_MUX_SELECT),
    .MEASURE_DURING_BALANCING(MEASURE_DURING_BALANCING), .MEAS_REQ(MEAS_REQ),
    .PAIR_DONE(PAIR_DONE), .MEAS_START(MEAS_START), .DELAY_BUSY(DELAY_BUSY),
    .STACK_MEASURE(STACK_MEASURE), .DIVIDER_ENGAGE(DIVIDER_ENGAGE),
    .CELL_MEASURE_EN(CELL_MEASURE_EN));
  // 100 MHz clock
  always #5 CLK = ~CLK;
  // hang guard: a stuck wait still reaches the verdict
  always @(posedge CLK) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_total++;
      stop_test();
    end
  end
  // one comparison, counted
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // apb transfer; idle edge at the end so calls never collide
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] rd, output logic e);
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    PSTRB <= s;
    @(posedge CLK);
    PENABLE <= 1'h1;
    // no local limit: only the bench ceiling ends a stuck wait
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'h1);
    rd = PRDATA;
    e = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
    @(posedge CLK);
  endtask
  // all sequencer-side outputs quiet and both registers zero
  task automatic reset_check();
    logic [31:0] rd;
    logic e;
    chk("outputs", {14'h0, MEAS_START, DELAY_BUSY, STACK_MEASURE, DIVIDER_ENGAGE,
      CELL_MEASURE_EN}, 32'h0);
    apb(1'h0, DLY_A, 32'h0, 4'h0, rd, e);
    chk("delay reset", rd, 32'h0);
    apb(1'h0, CH_A, 32'h0, 4'h0, rd, e);
    chk("channel reset", rd, 32'h0);
    $display("reset test done");
  endtask
  // trigger a measurement and count cycles until start
  task automatic fire(input int kind, input int lo, input int hi);
    int cnt;
    cnt = 1;
    if (kind == 1) PAIR_DONE <= 1'h1;
    else MEAS_REQ <= 1'h1;
    @(posedge CLK);
    PAIR_DONE <= 1'h0;
    MEAS_REQ <= 1'h0;
    // look just past each edge so the one-cycle start is seen while it stands
    #1;
    chk("busy", {31'h0, DELAY_BUSY}, 32'(lo > 1));
    while (MEAS_START !== 1'h1 && cnt < 2000) begin
      @(posedge CLK);
      #1;
      cnt++;
    end
    chk("start delay", 32'(cnt >= lo && cnt <= hi), 32'h1);
    @(posedge CLK);
  endtask
  initial begin
    logic [31:0] rd;
    logic e;
    int n;
    bdce_row_t rows [5];
    rows = '{'{DLY_A, 32'hffffa55a, 4'hf, 32'h0000a55a, 1'h0},
      '{DLY_A, 32'h12345678, 4'h1, 32'h0000a578, 1'h0},
      '{CH_A, 32'hffffffff, 4'hf, 32'h00007fff, 1'h0},
      '{CH_A, 32'h00002001, 4'h3, 32'h00002001, 1'h0},
      '{12'h194, 32'hffffffff, 4'hf, 32'h0, 1'h1}};
    repeat (16) @(posedge CLK);
    RST <= 1'h0;
    @(posedge CLK);
    reset_check();
    // write then read back every row
    foreach (rows[i]) begin
      apb(1'h1, rows[i].addr, rows[i].wdata, rows[i].strb, rd, e);
      chk("write err", {31'h0, e}, {31'h0, rows[i].err});
      apb(1'h0, rows[i].addr, 32'h0, 4'h0, rd, e);
      chk("read data", rd, rows[i].rdata);
      chk("read err", {31'h0, e}, {31'h0, rows[i].err});
      if (rows[i].addr == CH_A) begin
        chk("cells", {18'h0, CELL_MEASURE_EN}, rows[i].rdata & 32'h3fff);
      end
      $display("row %0d done", i);
    end
    // cell field 3 steps, switch field 5 steps; last case runs a zero field
    apb(1'h1, DLY_A, 32'h00000305, 4'hf, rd, e);
    for (int i = 0; i < 6; i++) begin
      if (i == 5) apb(1'h1, DLY_A, 32'h0, 4'hf, rd, e);
      n = (i == 5) ? 0 : (i % 2 == 1) ? 5 : 3;
      MANUAL_BAL <= (i != 2 && i != 3);
      AUTO_BAL <= (i == 2 || i == 3);
      AUTO_SWITCH_DISABLE <= (i != 4);
      ALTERNATE_MUX_SELECT <= (i % 2 == 1);
      MEASURE_DURING_BALANCING <= {1'h1, i % 2 == 1};
      @(posedge CLK);
      if (i == 4) fire(0, 1, 1);
      else fire(i / 2, n * TICK + 3, n * TICK + 3);
      $display("delay case %0d done", i);
    end
    // adc with block on, comparator with block on, adc with block off
    // block enable only set while the switch-sense mux is chosen
    ALTERNATE_MUX_SELECT <= 1'h1;
    for (int i = 0; i < 3; i++) begin
      apb(1'h1, CH_A, {17'h0, i != 2, 14'h0}, 4'hf, rd, e);
      SCAN_IS_ADC <= (i != 1);
      SCAN_ACTIVE <= 1'h1;
      repeat (2) @(posedge CLK);
      apb(1'h1, CH_A, {17'h0, i == 2, 14'h0}, 4'hf, rd, e);
      chk("block on", {30'h0, STACK_MEASURE, DIVIDER_ENGAGE}, {30'h0, {2{i == 0}}});
      SCAN_ACTIVE <= 1'h0;
      repeat (2) @(posedge CLK);
      chk("block off", {30'h0, STACK_MEASURE, DIVIDER_ENGAGE}, 32'h0);
      $display("scan case %0d done", i);
    end
    // second reset mid-run clears both registers
    apb(1'h1, CH_A, 32'h00007fff, 4'hf, rd, e);
    apb(1'h1, DLY_A, 32'h0000ffff, 4'hf, rd, e);
    RST <= 1'h1;
    repeat (3) @(posedge CLK);
    RST <= 1'h0;
    @(posedge CLK);
    reset_check();
    stop_test();
  end
endmodule
`default_nettype wire
